// File: gpc_pkg.sv
// Package for the four-port general I/O block with pin-change groups.
// Assumes one I/O clock and an 8-bit data bus from the core.
package gpc_pkg;
    localparam int          NUM_PORTS        = 4;
    localparam int          PORT_W           = 8;
    localparam int          NUM_PINS         = 32;
    localparam int          NUM_GROUPS       = 4;
    localparam int          ADDR_W           = 8;
    localparam logic [7:0]  ADDR_MASK_GROUP0 = 8'h6b;
    localparam logic [7:0]  ADDR_MASK_GROUP1 = 8'h6c;
    localparam logic [7:0]  ADDR_MASK_GROUP2 = 8'h6d;
    localparam logic [7:0]  ADDR_MASK_GROUP3 = 8'h73;
    localparam logic [7:0]  ADDR_GROUP_CTRL  = 8'h68;
    localparam logic [7:0]  ADDR_FLAGS       = 8'h1b;
    localparam logic [7:0]  ADDR_CORE_CTRL   = 8'h35;
    localparam logic [7:0]  ADDR_PORT_BASE   = 8'h00;
    localparam int          PUD_BIT          = 4;
    localparam logic [7:0]  RESET_BYTE       = 8'h00;
    localparam logic [3:0]  FLAG_MASK        = 4'hf;
endpackage : gpc_pkg

// File: gpc_port.sv
// Four 8-bit general I/O ports with four pin-change interrupt groups.
// Assumes a simple core I/O bus: address, write strobe, write data, read data.
`timescale 1ns/100ps
module gpc_port (
    // Clock and reset
    input  wire logic                          sys_clk_in,
    input  wire logic                          rstn_in,
    input  wire logic                          clk_en_in,
    // Core I/O bus
    input  wire logic [gpc_pkg::ADDR_W-1:0]    addr_in,
    input  wire logic                          wr_en_in,
    input  wire logic [7:0]                    wdata_in,
    output logic      [7:0]                    rdata_out,
    // Core interrupt interface
    input  wire logic                          global_irq_enable_in,
    input  wire logic [gpc_pkg::NUM_GROUPS-1:0] vector_ack_in,
    output logic      [gpc_pkg::NUM_GROUPS-1:0] vector_req_out,
    output logic                               wake_out,
    // Alternate function overrides
    input  wire logic [gpc_pkg::NUM_PINS-1:0]  alt_en_in,
    input  wire logic [gpc_pkg::NUM_PINS-1:0]  alt_out_in,
    input  wire logic [gpc_pkg::NUM_PINS-1:0]  alt_oe_in,
    // Pins
    input  wire logic [gpc_pkg::NUM_PINS-1:0]  pin_in,
    output logic      [gpc_pkg::NUM_PINS-1:0]  pin_out,
    output logic      [gpc_pkg::NUM_PINS-1:0]  pin_oen_out,
    output logic      [gpc_pkg::NUM_PINS-1:0]  pullup_out
);
    import gpc_pkg::*;

    logic [NUM_PINS-1:0]   port_output_reg_q;
    logic [NUM_PINS-1:0]   port_direction_reg_q;
    logic [NUM_PINS-1:0]   sync1_q;
    logic [NUM_PINS-1:0]   port_input_reg_q;
    logic [NUM_PINS-1:0]   prev_in_q;
    logic [NUM_PINS-1:0]   mask_q;
    logic [NUM_GROUPS-1:0] change_group_control_q;
    logic [NUM_GROUPS-1:0] pin_change_flags_q;
    logic [NUM_GROUPS-1:0] pin_change_flags_d;
    logic                  global_pullup_disable_q;

    // Address decode
    wire [1:0] port_idx     = addr_in[3:2];
    wire [1:0] port_sel     = addr_in[1:0];
    wire       port_hit     = (addr_in[7:4] == ADDR_PORT_BASE[7:4]);
    wire       wr_port      = wr_en_in && port_hit && (port_sel == 2'h0);
    wire       wr_dir       = wr_en_in && port_hit && (port_sel == 2'h1);
    wire       wr_pin       = wr_en_in && port_hit && (port_sel == 2'h2);
    wire       wr_flags     = wr_en_in && (addr_in == ADDR_FLAGS);
    wire       wr_ctrl      = wr_en_in && (addr_in == ADDR_GROUP_CTRL);
    wire       wr_core      = wr_en_in && (addr_in == ADDR_CORE_CTRL);

    wire [NUM_GROUPS-1:0] wr_mask = {wr_en_in && (addr_in == ADDR_MASK_GROUP3),
                                     wr_en_in && (addr_in == ADDR_MASK_GROUP2),
                                     wr_en_in && (addr_in == ADDR_MASK_GROUP1),
                                     wr_en_in && (addr_in == ADDR_MASK_GROUP0)};

    // Per-pin change detect, asynchronous to the synchroniser path for wake
    wire [NUM_PINS-1:0] changed = port_input_reg_q ^ prev_in_q;
    wire [NUM_PINS-1:0] async_change = pin_in ^ prev_in_q;
    logic [NUM_GROUPS-1:0] group_hit;
    logic [NUM_GROUPS-1:0] group_async;

    genvar g;
    generate
        for (g = 0; g < NUM_GROUPS; g++) begin : gen_grp
            // Mask bit and group enable together gate detection per pin
            assign group_hit[g]   = change_group_control_q[g] &&
                                    |(changed[g*PORT_W +: PORT_W] & mask_q[g*PORT_W +: PORT_W]);
            // Raw-pin compare needs no clock, so it can wake a stopped core
            assign group_async[g] = change_group_control_q[g] &&
                                    |(async_change[g*PORT_W +: PORT_W] & mask_q[g*PORT_W +: PORT_W]);
        end
    endgenerate

    // Set wins over both clear sources
    always_comb begin
        pin_change_flags_d = pin_change_flags_q;
        if (wr_flags) begin
            pin_change_flags_d = pin_change_flags_d & ~wdata_in[NUM_GROUPS-1:0];
        end
        pin_change_flags_d = (pin_change_flags_d & ~vector_ack_in) | group_hit;
    end

    // Vector request per group
    assign vector_req_out = pin_change_flags_q & change_group_control_q &
                            {NUM_GROUPS{global_irq_enable_in}};
    assign wake_out = |group_async;

    // Pad drive: alternate function only overrides its own pins
    wire [NUM_PINS-1:0] eff_dir = (alt_en_in & alt_oe_in) | (~alt_en_in & port_direction_reg_q);
    wire [NUM_PINS-1:0] eff_out = (alt_en_in & alt_out_in) | (~alt_en_in & port_output_reg_q);
    // Reset gates the drive directly, so even an override tri-states with no clock
    wire [NUM_PINS-1:0] drive_en = eff_dir & {NUM_PINS{rstn_in}};
    assign pin_oen_out = ~drive_en;
    assign pin_out     = eff_out & drive_en;
    // Pull-up only on inputs with output bit set, unless globally disabled
    assign pullup_out  = ~eff_dir & eff_out & {NUM_PINS{~global_pullup_disable_q & rstn_in}};

    // Per-port registers; byte writes touch only the addressed port
    genvar p;
    generate
        for (p = 0; p < NUM_PORTS; p++) begin : gen_port
            wire sel = (port_idx == 2'(p));
            always_ff @(posedge sys_clk_in or negedge rstn_in) begin
                if (!rstn_in) begin
                    port_output_reg_q[p*PORT_W +: PORT_W]    <= RESET_BYTE;
                    port_direction_reg_q[p*PORT_W +: PORT_W] <= RESET_BYTE;
                    mask_q[p*PORT_W +: PORT_W]               <= RESET_BYTE;
                end else if (clk_en_in) begin
                    if (sel && wr_port) begin
                        port_output_reg_q[p*PORT_W +: PORT_W] <= wdata_in;
                    end else if (sel && wr_pin) begin
                        // Toggle instead of store
                        port_output_reg_q[p*PORT_W +: PORT_W] <=
                            port_output_reg_q[p*PORT_W +: PORT_W] ^ wdata_in;
                    end
                    if (sel && wr_dir) begin
                        port_direction_reg_q[p*PORT_W +: PORT_W] <= wdata_in;
                    end
                    if (wr_mask[p]) begin
                        mask_q[p*PORT_W +: PORT_W] <= wdata_in;
                    end
                end
            end
        end
    endgenerate

    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            sync1_q                 <= '0;
            port_input_reg_q        <= '0;
            prev_in_q               <= '0;
            change_group_control_q  <= '0;
            pin_change_flags_q      <= '0;
            global_pullup_disable_q <= 1'b0;
        end else if (clk_en_in) begin
            sync1_q            <= pin_in;
            port_input_reg_q   <= sync1_q;
            prev_in_q          <= port_input_reg_q;
            pin_change_flags_q <= pin_change_flags_d;
            if (wr_ctrl) begin
                change_group_control_q <= wdata_in[NUM_GROUPS-1:0];
            end
            if (wr_core) begin
                global_pullup_disable_q <= wdata_in[PUD_BIT];
            end
        end
    end

    // Read mux; data output registered
    logic [7:0] rd_d;
    always_comb begin
        rd_d = 8'h00;
        if (port_hit) begin
            case (port_sel)
                2'h0:    rd_d = port_output_reg_q[port_idx*PORT_W +: PORT_W];
                2'h1:    rd_d = port_direction_reg_q[port_idx*PORT_W +: PORT_W];
                2'h2:    rd_d = port_input_reg_q[port_idx*PORT_W +: PORT_W];
                default: rd_d = 8'h00;
            endcase
        end
        if (addr_in == ADDR_MASK_GROUP0) rd_d = mask_q[0*PORT_W +: PORT_W];
        if (addr_in == ADDR_MASK_GROUP1) rd_d = mask_q[1*PORT_W +: PORT_W];
        if (addr_in == ADDR_MASK_GROUP2) rd_d = mask_q[2*PORT_W +: PORT_W];
        if (addr_in == ADDR_MASK_GROUP3) rd_d = mask_q[3*PORT_W +: PORT_W];
        if (addr_in == ADDR_GROUP_CTRL)  rd_d = {4'h0, change_group_control_q};
        if (addr_in == ADDR_FLAGS)       rd_d = {4'h0, pin_change_flags_q & FLAG_MASK};
        if (addr_in == ADDR_CORE_CTRL)   rd_d = 8'(global_pullup_disable_q) << PUD_BIT;
    end

    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            rdata_out <= 8'h00;
        end else if (clk_en_in) begin
            rdata_out <= rd_d;
        end
    end

    // Assertions
    property p_flag_set;
        @(posedge sys_clk_in) disable iff (!rstn_in)
        (clk_en_in && group_hit[0]) |=> pin_change_flags_q[0];
    endproperty
    a_flag_set: assert property (p_flag_set) else $error("flag0 not set on change");

    property p_vec;
        @(posedge sys_clk_in) disable iff (!rstn_in)
        vector_req_out[1] |-> (pin_change_flags_q[1] && change_group_control_q[1] && global_irq_enable_in);
    endproperty
    a_vec: assert property (p_vec) else $error("vector request without cause");

    property p_ack_clr;
        @(posedge sys_clk_in) disable iff (!rstn_in)
        (clk_en_in && vector_ack_in[2] && !group_hit[2]) |=> !pin_change_flags_q[2];
    endproperty
    a_ack_clr: assert property (p_ack_clr) else $error("flag2 not cleared by ack");

    property p_w1c;
        @(posedge sys_clk_in) disable iff (!rstn_in)
        (clk_en_in && wr_flags && wdata_in[3] && !group_hit[3]) |=> !pin_change_flags_q[3];
    endproperty
    a_w1c: assert property (p_w1c) else $error("flag3 not cleared by write one");

    property p_w0;
        @(posedge sys_clk_in) disable iff (!rstn_in)
        (clk_en_in && wr_flags && !wdata_in[0] && pin_change_flags_q[0] && !vector_ack_in[0])
        |=> pin_change_flags_q[0];
    endproperty
    a_w0: assert property (p_w0) else $error("flag0 lost on write zero");

    property p_mask;
        @(posedge sys_clk_in) disable iff (!rstn_in)
        (mask_q[7:0] == 8'h00) |-> !group_hit[0];
    endproperty
    a_mask: assert property (p_mask) else $error("detection with mask clear");

    property p_toggle;
        @(posedge sys_clk_in) disable iff (!rstn_in)
        (clk_en_in && wr_pin && port_idx == 2'h0) |=>
        (port_output_reg_q[7:0] == ($past(port_output_reg_q[7:0]) ^ $past(wdata_in)));
    endproperty
    a_toggle: assert property (p_toggle) else $error("input write did not toggle");

    property p_pud;
        @(posedge sys_clk_in) disable iff (!rstn_in)
        global_pullup_disable_q |-> (pullup_out == '0);
    endproperty
    a_pud: assert property (p_pud) else $error("pull-up active while disabled");

    property p_drive;
        @(posedge sys_clk_in) disable iff (!rstn_in)
        (!alt_en_in[5] && port_direction_reg_q[5]) |-> (!pin_oen_out[5] && pin_out[5] == port_output_reg_q[5]);
    endproperty
    a_drive: assert property (p_drive) else $error("output pin not driven");

    // Reset must tri-state the pads even before any clock edge arrives
    property p_reset_tri;
        @(posedge sys_clk_in)
        !rstn_in |-> (pin_oen_out == '1 && pin_out == '0);
    endproperty
    a_reset_tri: assert property (p_reset_tri) else $error("pins driven during reset");

    property p_dir_in;
        @(posedge sys_clk_in) disable iff (!rstn_in)
        (!alt_en_in[5] && !port_direction_reg_q[5]) |-> pin_oen_out[5];
    endproperty
    a_dir_in: assert property (p_dir_in) else $error("input pin driven");

    property p_pullup;
        @(posedge sys_clk_in) disable iff (!rstn_in)
        (!alt_en_in[2] && !port_direction_reg_q[2] && port_output_reg_q[2] && !global_pullup_disable_q)
        |-> pullup_out[2];
    endproperty
    a_pullup: assert property (p_pullup) else $error("pull-up missing on input");

    // Group enable low must keep the flag from rising, whatever the mask says
    property p_grp_gate;
        @(posedge sys_clk_in) disable iff (!rstn_in)
        (clk_en_in && !change_group_control_q[1] && !pin_change_flags_q[1]) |=> !pin_change_flags_q[1];
    endproperty
    a_grp_gate: assert property (p_grp_gate) else $error("flag1 set with group disabled");

    property p_ctrl_wr;
        @(posedge sys_clk_in) disable iff (!rstn_in)
        (clk_en_in && wr_ctrl) |=> (change_group_control_q == $past(wdata_in[3:0]));
    endproperty
    a_ctrl_wr: assert property (p_ctrl_wr) else $error("group control write lost");

    property p_port_iso;
        @(posedge sys_clk_in) disable iff (!rstn_in)
        (clk_en_in && wr_dir && port_idx == 2'h1) |=>
        (port_direction_reg_q[7:0] == $past(port_direction_reg_q[7:0]));
    endproperty
    a_port_iso: assert property (p_port_iso) else $error("write to port1 disturbed port0");

    // Clock enable low must freeze the change flags and the port output registers
    property p_freeze;
        @(posedge sys_clk_in) disable iff (!rstn_in)
        !clk_en_in |=> ($stable(pin_change_flags_q) && $stable(port_output_reg_q));
    endproperty
    a_freeze: assert property (p_freeze) else $error("state moved with clock enable low");

    c_flag: cover property (@(posedge sys_clk_in) disable iff (!rstn_in) pin_change_flags_q[0]);
    c_vec:  cover property (@(posedge sys_clk_in) disable iff (!rstn_in) vector_req_out[3]);
    c_wake: cover property (@(posedge sys_clk_in) disable iff (!rstn_in) wake_out);
    c_ack:  cover property (@(posedge sys_clk_in) disable iff (!rstn_in) vector_ack_in[0] && pin_change_flags_q[0]);
endmodule : gpc_port

// File: gpc_pad_model.sv
// Pad model: resolves each pad from the block's drive, an outside driver and the pull-up.
// Assumes the block drives a pad while its output enable is low.
`timescale 1ns/100ps
module gpc_pad_model (
    // Clock
    input  wire logic        sys_clk_in,
    // Block side
    input  wire logic [31:0] drv_val_in,
    input  wire logic [31:0] drv_oen_in,
    input  wire logic [31:0] pullup_in,
    // Outside driver
    input  wire logic [31:0] ext_en_in,
    input  wire logic [31:0] ext_val_in,
    // Resolved pad level
    output logic      [31:0] level_out
);
    logic [31:0] float_q = 32'h5555_5555;
    // Undriven pads change every cycle so no test leans on a settled unknown
    always_ff @(posedge sys_clk_in) float_q <= ~float_q;
    always_comb begin
        for (int i = 0; i < 32; i++) begin
            if (!drv_oen_in[i]) level_out[i] = drv_val_in[i];
            else if (ext_en_in[i]) level_out[i] = ext_val_in[i];
            else if (pullup_in[i]) level_out[i] = 1'b1;
            else level_out[i] = float_q[i];
        end
    end
endmodule : gpc_pad_model

// File: gpc_port_tb_top.sv
// Testbench for gpc_port: byte bus tasks, a pad model and one task per scenario.
// Assumes the package addresses and a single 20 MHz clock.
`timescale 1ns/100ps
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin miscompares++; $display("MISMATCH %0t %h %h", $time, (a), (e)); end end
module gpc_port_tb_top;
    import gpc_pkg::*;
    localparam logic [7:0] MADDR [4] = '{ADDR_MASK_GROUP0, ADDR_MASK_GROUP1, ADDR_MASK_GROUP2, ADDR_MASK_GROUP3};
    logic        sys_clk_in = 1'b0;
    logic        rstn_in;
    logic        ce_q       = 1'b1;
    logic [7:0]  addr_in    = 8'h00;
    logic        wr_en_in   = 1'b0;
    logic [7:0]  wdata_in   = 8'h00;
    logic        gie_q      = 1'b0;
    logic [3:0]  ack_q      = 4'h0;
    logic [31:0] alt_en_q   = '0;
    logic [31:0] ext_en_q   = '1;
    logic [31:0] ext_val_q  = '0;
    logic [7:0]  rdata_out, rd_q;
    logic [3:0]  vector_req_out;
    logic        wake_out;
    logic [31:0] pin_in, pin_out, pin_oen_out, pullup_out;
    int          miscompares = 0;
    int          tests_run   = 0;

    gpc_port i_dut (.sys_clk_in(sys_clk_in), .rstn_in(rstn_in), .clk_en_in(ce_q), .addr_in(addr_in),
        .wr_en_in(wr_en_in), .wdata_in(wdata_in), .rdata_out(rdata_out), .global_irq_enable_in(gie_q),
        .vector_ack_in(ack_q), .vector_req_out(vector_req_out), .wake_out(wake_out), .alt_en_in(alt_en_q),
        .alt_out_in('0), .alt_oe_in('0), .pin_in(pin_in), .pin_out(pin_out), .pin_oen_out(pin_oen_out),
        .pullup_out(pullup_out));
    gpc_pad_model i_pads (.sys_clk_in(sys_clk_in), .drv_val_in(pin_out), .drv_oen_in(pin_oen_out),
        .pullup_in(pullup_out), .ext_en_in(ext_en_q), .ext_val_in(ext_val_q), .level_out(pin_in));

    initial begin
        forever #25 sys_clk_in = ~sys_clk_in;
    end

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk_in);
        addr_in  <= a;
        wdata_in <= d;
        wr_en_in <= 1'b1;
        @(posedge sys_clk_in);
        wr_en_in <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a);
        @(posedge sys_clk_in);
        addr_in <= a;
        @(posedge sys_clk_in);
        #1 rd_q = rdata_out;
    endtask : rd

    // Flip one outside pad, check the unclocked wake path, then let the flag path settle
    task automatic tog(input int i, input logic w);
        @(posedge sys_clk_in);
        ext_val_q[i] <= ~ext_val_q[i];
        #1 `CHK(wake_out, w)
        repeat (5) @(posedge sys_clk_in);
    endtask : tog

    task automatic t_regs();
        for (int i = 0; i < 4; i++) begin
            rd(MADDR[i]);
            `CHK(rd_q, 8'h00)
            wr(ADDR_PORT_BASE + 8'(4 * i), 8'h5a ^ 8'(i));
            wr(ADDR_PORT_BASE + 8'(4 * i + 1), 8'hc3);
            wr(ADDR_PORT_BASE + 8'(4 * i + 3), 8'hff);
            rd(ADDR_PORT_BASE + 8'(4 * i));
            `CHK(rd_q, 8'h5a ^ 8'(i))
            rd(ADDR_PORT_BASE + 8'(4 * i + 1));
            `CHK(rd_q, 8'hc3)
            rd(ADDR_PORT_BASE + 8'(4 * i + 3));
            `CHK(rd_q, 8'h00)
        end
        rd(ADDR_GROUP_CTRL);
        `CHK(rd_q, 8'h00)
        wr(8'hf0, 8'h77);
        rd(8'hf0);
        `CHK(rd_q, 8'h00)
        // A write while the clock enable is low must leave no trace
        @(posedge sys_clk_in);
        ce_q <= 1'b0;
        wr(ADDR_GROUP_CTRL, 8'h05);
        @(posedge sys_clk_in);
        ce_q <= 1'b1;
        rd(ADDR_GROUP_CTRL);
        `CHK(rd_q, 8'h00)
    endtask : t_regs

    task automatic t_drive();
        @(posedge sys_clk_in);
        ext_en_q[7:0] <= 8'h00;
        alt_en_q[0]   <= 1'b1;
        wr(ADDR_PORT_BASE, 8'ha5);
        wr(ADDR_PORT_BASE + 8'h01, 8'hf0);
        repeat (3) @(posedge sys_clk_in);
        rd(ADDR_PORT_BASE + 8'h02);
        `CHK(pin_oen_out[7:1], 7'h07)
        `CHK(pin_out[7:1], 7'h50)
        `CHK(pullup_out[7:1], 7'h02)
        `CHK({rd_q[7:4], rd_q[2]}, 5'h15)
        wr(ADDR_PORT_BASE + 8'h02, 8'h01);
        rd(ADDR_PORT_BASE);
        `CHK(rd_q, 8'ha4)
        wr(ADDR_CORE_CTRL, 8'h10);
        #1 `CHK(pullup_out, 32'h0000_0000)
        wr(ADDR_CORE_CTRL, 8'h00);
        @(posedge sys_clk_in);
        ext_en_q <= '1;
        alt_en_q <= '0;
    endtask : t_drive

    task automatic t_irq();
        wr(ADDR_GROUP_CTRL, 8'h0f);
        gie_q <= 1'b1;
        for (int g = 0; g < 4; g++) begin
            wr(MADDR[g], 8'h08);
            tog(8 * g + 4, 1'b0);
            `CHK(vector_req_out, 4'h0)
            tog(8 * g + 3, 1'b1);
            `CHK(vector_req_out, 4'(1 << g))
            ack_q[g] <= 1'b1;
            @(posedge sys_clk_in);
            ack_q <= 4'h0;
            #1 `CHK(vector_req_out, 4'h0)
        end
    endtask : t_irq

    task automatic t_w1c();
        @(posedge sys_clk_in);
        gie_q <= 1'b0;
        tog(11, 1'b1);
        `CHK(vector_req_out, 4'h0)
        wr(ADDR_FLAGS, 8'hfd);
        rd(ADDR_FLAGS);
        `CHK(rd_q, 8'h02)
        wr(ADDR_FLAGS, 8'h02);
        rd(ADDR_FLAGS);
        `CHK(rd_q, 8'h00)
        // Group disabled: a masked change must neither wake nor set the flag
        wr(ADDR_GROUP_CTRL, 8'h0d);
        tog(11, 1'b0);
        rd(ADDR_FLAGS);
        `CHK(rd_q, 8'h00)
    endtask : t_w1c

    task automatic conclude();
        if (miscompares == 0 && tests_run > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : conclude

    initial begin
        rstn_in <= 1'b0;
        #1 `CHK(pin_oen_out, 32'hffff_ffff)
        repeat (5) @(posedge sys_clk_in);
        rstn_in <= 1'b1;
        t_regs();
        t_drive();
        t_irq();
        t_w1c();
        @(posedge sys_clk_in);
        rstn_in <= 1'b0;
        #1 `CHK(pin_oen_out, 32'hffff_ffff)
        conclude();
    end

    initial begin
        #(50 * 5000);
        miscompares++;
        conclude();
    end
endmodule : gpc_port_tb_top
